/* File: shared/cil_defs.svh */
`ifndef CIL_DEFS_SVH
`define CIL_DEFS_SVH

// ****************************************
// register byte addresses
// ****************************************
`define CIL_ADDR_W       8
`define CIL_A_CTRL       8'h00
`define CIL_A_TRIG       8'h04
`define CIL_A_DEB0       8'h08
`define CIL_A_DEB1       8'h0c
`define CIL_A_DEB2       8'h10
`define CIL_A_DEB3       8'h14
`define CIL_A_STAT       8'h18

// ****************************************
// control word fields
// ****************************************
`define CIL_C_DIR        0
`define CIL_C_OINV       1
`define CIL_C_GSRC       6:4
`define CIL_C_SSRC       10:8
`define CIL_C_GUSR       12
`define CIL_C_SUSR       13
`define CIL_C_NARROW     16
`define CIL_C_IINV       23:20
`define CIL_CTRL_MASK    32'h00f1_3773
`define CIL_CTRL_RST     32'h0000_0000

// ****************************************
// trigger source word fields
// ****************************************
`define CIL_T_ACQ        2:0
`define CIL_T_FRM        6:4
`define CIL_TRIG_MASK    32'h0000_0077
`define CIL_TRIG_RST     32'h0000_0000

// ****************************************
// source encodings
// ****************************************
`define CIL_IN_NONE      3'h0
`define CIL_IN_GPIO      3'h1
`define CIL_IN_CC1       3'h2
`define CIL_IN_CC2       3'h3
`define CIL_IN_CC3       3'h4
`define CIL_OUT_ACQW     3'h0
`define CIL_OUT_FRMW     3'h1
`define CIL_OUT_EXPO     3'h2
`define CIL_OUT_FCYC     3'h3
`define CIL_OUT_USER     3'h4

// ****************************************
// debounce timing
// ****************************************
`define CIL_DEB_W        20
`define CIL_DEB_RST      20'h0_0000
`define CIL_UNIT_NS      1000
`define CIL_CLK_NS       100
`define CIL_PRE_W        4
`define CIL_PRE_LAST     4'((`CIL_UNIT_NS / `CIL_CLK_NS) - 1)

`endif

/* File: shared/cil_pkg.sv */
`default_nettype none
package cil_pkg;

  // camera-generated output signals, same clock domain
  typedef struct packed {
    logic acq_trig_wait;
    logic frame_trig_wait;
    logic exposure_active;
    logic frame_cycle;
  } cil_cam_s;

  // trigger pulses toward the trigger logic
  typedef struct packed {
    logic acq_start;
    logic frame_start;
  } cil_trig_s;

  // whole block state
  typedef struct packed {
    logic [31:0]            ctrl;
    logic [31:0]            trig;
    logic [3:0][19:0]       deb_time;
    logic [3:0][19:0]       deb_cnt;
    logic [3:0]             sync1;
    logic [3:0]             sync2;
    logic [3:0]             sync3;
    logic [3:0]             raw;
    logic [3:0]             pre;
    logic [31:0]            rdata;
    logic                   gpio_out;
    logic                   gpio_oe_n;
    logic                   spare;
    logic                   spare_en;
    cil_trig_s              trig_out;
  } cil_state_s;

endpackage
`default_nettype wire

/* File: logic/cil_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cil_defs.svh"

// Function
// - one general purpose line whose direction software picks, input feeding the input path, output driven from the output path.
// - the general purpose line in input direction can be chosen as acquisition start or frame start trigger source.
// - with output inversion off, a high internal output turns the output switch on and a low one turns it off.
// - with output inversion on, a low internal output turns the output switch on and a high one turns it off.
// - in output direction the line follows exactly one selected source among the standard output signals.
// - control inputs one to three are accepted and each can be chosen as acquisition or frame start trigger source.
// - the spare link bit follows one selected source: acquisition wait, frame wait, exposure active, frame cycle or user level.
// - a line set to user settable follows the level software last wrote instead of a camera signal.
// - the spare bit is not carried when the narrow one-row eight or ten tap geometry is chosen.
// - each input debouncer passes a level change only after it has held for the programmed time, delaying valid edges.
// - each of the four input lines has its own inversion bit, one inverting and zero passing unchanged.
module cil_top (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic [`CIL_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [31:0]                 reg_rdata,
  input  wire logic                   gpio_in,
  output logic                        gpio_out,
  output logic                        gpio_oe_n,
  input  wire logic [2:0]             cc_in,
  input  wire cil_pkg::cil_cam_s      cam_sig,
  output cil_pkg::cil_trig_s          trig_out,
  output logic                        cl_spare,
  output logic                        cl_spare_en
);
  import cil_pkg::*;

  cil_state_s st_reg;
  cil_state_s st_next;

  // ****************************************
  // register map
  // ****************************************

  // ctrl word, unused bits read back as zero:
  //   bit 0       line direction, 1 lets the block drive the pin
  //   bit 1       output inversion, gpio only
  //   bits 6:4    gpio output source
  //   bits 10:8   spare bit source, never inverted
  //   bit 12      gpio user level
  //   bit 13      spare user level
  //   bit 16      narrow tap geometry, spare bit absent
  //   bits 23:20  input inversion, gpio then cc1..cc3
  // trig word:
  //   bits 2:0    acquisition start source
  //   bits 6:4    frame start source
  // input source codes: none, gpio, cc1, cc2, cc3; higher codes select nothing
  // output source codes: acq wait, frame wait, exposure, frame cycle, user; higher codes give low
  // debounce words: 20-bit time in microsecond ticks, one per input line
  // status word, read only:
  //   bits 3:0    input lines after debounce and inversion
  //   bits 5:4    acquisition and frame start levels
  //   bit 6       gpio output switch state
  //   bit 7       spare bit level
  //   bit 8       spare bit present
  // limitation: the tick is shared by all lines, so a valid edge
  //   may land up to one tick later than the programmed time

  // ****************************************
  // functions
  // ****************************************

  // pick one input line as a trigger source; gpio only counts as input
  function automatic logic in_select(input logic [2:0] src, input logic [3:0] lines, input logic gpio_ok);
    logic v;
    v = 1'b0;
    case (src)
      `CIL_IN_GPIO: v = lines[0] & gpio_ok;
      `CIL_IN_CC1:  v = lines[1];
      `CIL_IN_CC2:  v = lines[2];
      `CIL_IN_CC3:  v = lines[3];
      default:      v = 1'b0;
    endcase
    return v;
  endfunction

  // pick exactly one output source; unknown codes read as low
  function automatic logic out_select(input logic [2:0] src, input cil_cam_s cam, input logic user);
    logic v;
    v = 1'b0;
    case (src)
      `CIL_OUT_ACQW: v = cam.acq_trig_wait;
      `CIL_OUT_FRMW: v = cam.frame_trig_wait;
      `CIL_OUT_EXPO: v = cam.exposure_active;
      `CIL_OUT_FCYC: v = cam.frame_cycle;
      `CIL_OUT_USER: v = user;
      default:       v = 1'b0;
    endcase
    return v;
  endfunction

  // register read mux, unmapped addresses answer zero
  function automatic logic [31:0] reg_read(input logic [`CIL_ADDR_W-1:0] a, input cil_state_s s, input logic [31:0] stat);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `CIL_A_CTRL: v = s.ctrl;
      `CIL_A_TRIG: v = s.trig;
      `CIL_A_DEB0: v = {12'h000, s.deb_time[0]};
      `CIL_A_DEB1: v = {12'h000, s.deb_time[1]};
      `CIL_A_DEB2: v = {12'h000, s.deb_time[2]};
      `CIL_A_DEB3: v = {12'h000, s.deb_time[3]};
      `CIL_A_STAT: v = stat;
      default:     v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // ****************************************
  // next state
  // ****************************************

  // combinational helpers, each set inside the process before its first use
  logic        tick;
  logic [3:0]  lines;
  logic [31:0] stat;
  logic        dir_out;
  logic        gsel;

  // one process computes the whole next state
  always_comb begin
    st_next = st_reg;
    dir_out = st_reg.ctrl[`CIL_C_DIR];

    // three-stage synchroniser on pins; bit 0 is gpio, 1..3 are cc lines
    st_next.sync1 = {cc_in, gpio_in};
    st_next.sync2 = st_reg.sync1;
    st_next.sync3 = st_reg.sync2;

    // microsecond prescaler shared by all debouncers
    tick = (st_reg.pre == `CIL_PRE_LAST);
    st_next.pre = tick ? 4'h0 : st_reg.pre + 4'h1;

    // debounce: count ticks only while stable and differing from the held level;
    // the level passes on the tick after the count reaches the time, so a
    // pulse shorter than the programmed time never gets through
    for (int i = 0; i < 4; i++) begin
      if (st_reg.sync2[i] != st_reg.sync3[i] || st_reg.sync3[i] == st_reg.raw[i]) begin
        st_next.deb_cnt[i] = `CIL_DEB_RST;
      end else if (st_reg.deb_time[i] == `CIL_DEB_RST
                   || (tick && st_reg.deb_cnt[i] >= st_reg.deb_time[i])) begin
        st_next.raw[i] = st_reg.sync3[i];
        st_next.deb_cnt[i] = `CIL_DEB_RST;
      end else if (tick) begin
        st_next.deb_cnt[i] = st_reg.deb_cnt[i] + 20'h0_0001;
      end
    end

    // per-line inversion after the debouncer
    lines = st_reg.raw ^ st_reg.ctrl[`CIL_C_IINV];

    // trigger source selection; gpio is ignored while it drives
    st_next.trig_out.acq_start   = in_select(st_reg.trig[`CIL_T_ACQ], lines, ~dir_out);
    st_next.trig_out.frame_start = in_select(st_reg.trig[`CIL_T_FRM], lines, ~dir_out);

    // gpio output path: source, then inversion, driver off in input direction
    gsel = out_select(st_reg.ctrl[`CIL_C_GSRC], cam_sig, st_reg.ctrl[`CIL_C_GUSR]);
    st_next.gpio_out  = dir_out & (gsel ^ st_reg.ctrl[`CIL_C_OINV]);
    st_next.gpio_oe_n = ~dir_out;

    // spare bit held low and flagged absent in narrow tap geometry
    st_next.spare_en = ~st_reg.ctrl[`CIL_C_NARROW];
    st_next.spare    = ~st_reg.ctrl[`CIL_C_NARROW]
                     & out_select(st_reg.ctrl[`CIL_C_SSRC], cam_sig, st_reg.ctrl[`CIL_C_SUSR]);

    // register writes; masks keep unused bits at zero
    if (reg_wr) begin
      case (reg_addr)
        `CIL_A_CTRL: st_next.ctrl = reg_wdata & `CIL_CTRL_MASK;
        `CIL_A_TRIG: st_next.trig = reg_wdata & `CIL_TRIG_MASK;
        `CIL_A_DEB0: st_next.deb_time[0] = reg_wdata[`CIL_DEB_W-1:0];
        `CIL_A_DEB1: st_next.deb_time[1] = reg_wdata[`CIL_DEB_W-1:0];
        `CIL_A_DEB2: st_next.deb_time[2] = reg_wdata[`CIL_DEB_W-1:0];
        `CIL_A_DEB3: st_next.deb_time[3] = reg_wdata[`CIL_DEB_W-1:0];
        default: ;
      endcase
    end

    // status shows debounced lines, triggers and driven outputs
    stat = {23'h00_0000, st_reg.spare_en, st_reg.spare, st_reg.gpio_out,
            st_reg.trig_out.frame_start, st_reg.trig_out.acq_start, lines};
    st_next.rdata = reg_rd ? reg_read(reg_addr, st_reg, stat) : 32'h0000_0000;
  end

  // ****************************************
  // state register
  // ****************************************

  // reset leaves gpio as an input with its driver off
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.gpio_oe_n <= 1'b1;
      st_reg.spare_en <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata   = st_reg.rdata;
  assign gpio_out    = st_reg.gpio_out;
  assign gpio_oe_n   = st_reg.gpio_oe_n;
  assign trig_out    = st_reg.trig_out;
  assign cl_spare    = st_reg.spare;
  assign cl_spare_en = st_reg.spare_en;

endmodule // cil_top
`default_nettype wire

/* File: bench/cil_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cil_defs.svh"
// ****************************************
// output routing checks
// ****************************************
module cil_chk (
  input wire logic                   mclk,
  input wire logic                   rst_n,
  input wire logic [`CIL_ADDR_W-1:0] reg_addr,
  input wire logic [31:0]            reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [31:0]            reg_rdata,
  input wire logic                   gpio_out,
  input wire logic                   gpio_oe_n,
  input wire cil_pkg::cil_cam_s      cam_sig,
  input wire logic                   cl_spare,
  input wire logic                   cl_spare_en
);
  import cil_pkg::*;
  logic [31:0] c_reg;
  logic [31:0] c_old;
  logic        st;
  // shadow of the control word; outputs are judged only once it has settled
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      c_reg <= '0;
      c_old <= '0;
    end else begin
      if (reg_wr && reg_addr == `CIL_A_CTRL) c_reg <= reg_wdata & `CIL_CTRL_MASK;
      c_old <= c_reg;
    end
  end
  assign st = (c_reg == c_old);
  // expected source level, codes above user give 0
  function automatic logic pick(input logic [3:0] c, input logic [2:0] s, input logic u);
    return (s == 3'h4) ? u : (s < 3'h4) ? c[~s[1:0]] : 1'b0;
  endfunction
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data not idle");
  oe_input_a: assert property (st && !c_reg[0] |-> gpio_oe_n && !gpio_out) else $error("driver on");
  oe_output_a: assert property (st && c_reg[0] |-> !gpio_oe_n) else $error("driver off");
  gpio_plain_a: assert property (st && c_reg[0] && !c_reg[1]
    |-> gpio_out == pick($past(cam_sig), c_reg[6:4], c_reg[12])) else $error("gpio level wrong");
  gpio_inv_a: assert property (st && c_reg[0] && c_reg[1]
    |-> gpio_out == !pick($past(cam_sig), c_reg[6:4], c_reg[12])) else $error("gpio inverse wrong");
  user_level_a: assert property (st && c_reg[0] && !c_reg[1] && c_reg[6:4] == 3'h4
    |-> gpio_out == c_reg[12]) else $error("user level wrong");
  spare_src_a: assert property (st && !c_reg[16]
    |-> cl_spare_en && cl_spare == pick($past(cam_sig), c_reg[10:8], c_reg[13])) else $error("spare wrong");
  spare_narrow_a: assert property (st && c_reg[16] |-> !cl_spare_en && !cl_spare) else $error("spare carried");
  cover property (st && c_reg[0] && c_reg[1]);
  cover property (st && c_reg[16]);
  cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule // cil_chk
bind cil_top cil_chk u_chk (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .gpio_out, .gpio_oe_n, .cam_sig, .cl_spare, .cl_spare_en);
`default_nettype wire

/* File: bench/cil_grabber.sv */
`timescale 1ns/1ns
`default_nettype none
// trigger sources: grabber on the control inputs, outside circuit on the pin
module cil_grabber (
  input wire logic       mclk,
  input wire logic [3:0] lvl,
  input wire logic       gpio_out,
  input wire logic       gpio_oe_n,
  output logic           gpio_in,
  output logic [2:0]     cc_in
);
  logic [3:0] drv = 4'h0;
  // levels move just after an edge and hold as long as asked
  always @(posedge mclk) drv <= lvl;
  // outside party lets go while the camera drives the pin
  assign gpio_in = gpio_oe_n ? drv[0] : gpio_out;
  assign cc_in = drv[3:1];
endmodule // cil_grabber
`default_nettype wire

/* File: bench/cil_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cil_defs.svh"
module cil_top_tb;
  import cil_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic        gpio_in, gpio_out, gpio_oe_n, cl_spare, cl_spare_en;
  logic [2:0]  cc_in;
  logic [3:0]  lvl = 4'h0;
  cil_cam_s    cam_sig = '0;
  cil_trig_s   trig_out;
  int          err_total = 0;
  int          checked = 0;
  cil_top DUT (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .gpio_in, .gpio_out,
    .gpio_oe_n, .cc_in, .cam_sig, .trig_out, .cl_spare, .cl_spare_en);
  cil_grabber u_fg (.mclk, .lvl, .gpio_out, .gpio_oe_n, .gpio_in, .cc_in);
  // ****************************************
  // bus tasks and compare
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic pins(input int n, input logic [31:0] exp);
    repeat (n) @(posedge mclk);
    #1 chk({28'h0, gpio_oe_n, gpio_out, cl_spare, cl_spare_en}, exp);
  endtask
  task automatic trg(input int n, input logic [31:0] exp);
    repeat (n) @(posedge mclk);
    #1 chk({30'h0, trig_out}, exp);
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // free-running clock, 100 ns period
  initial forever #50 mclk = ~mclk;
  // hang guard, well past the expected run length
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    rd(`CIL_A_CTRL, 32'h0);
    rd(`CIL_A_STAT, 32'h100);
    rd(8'h1c, 32'h0);
    wr(`CIL_A_CTRL, 32'hffff_ffff);
    rd(`CIL_A_CTRL, `CIL_CTRL_MASK);
    for (int inv = 0; inv < 2; inv++) begin
      for (int k = 0; k < 5; k++) begin
        wr(`CIL_A_CTRL, 32'h3001 | 32'(inv << 1) | 32'(k << 4) | 32'(k << 8));
        cam_sig <= cil_cam_s'(4'(8 >> k));
        pins(3, inv ? 32'h3 : 32'h7);
        wr(`CIL_A_CTRL, 32'h0001 | 32'(inv << 1) | 32'(k << 4) | 32'(k << 8));
        cam_sig <= cil_cam_s'(~4'(8 >> k));
        pins(3, inv ? 32'h5 : 32'h1);
      end
    end
    wr(`CIL_A_CTRL, 32'h1_3401);
    pins(3, 32'h4);
    wr(`CIL_A_CTRL, 32'h3040);
    pins(3, 32'hb);
    cam_sig <= '0;
    wr(`CIL_A_CTRL, 32'h0);
    for (int s = 1; s < 5; s++) begin
      wr(`CIL_A_TRIG, 32'(s | (s << 4)));
      lvl <= 4'(1 << (s - 1));
      trg(10, 32'h3);
      lvl <= 4'h0;
      trg(10, 32'h0);
    end
    wr(`CIL_A_CTRL, 32'h1041);
    wr(`CIL_A_TRIG, 32'h11);
    trg(10, 32'h0);
    wr(`CIL_A_CTRL, 32'h20_0000);
    wr(`CIL_A_TRIG, 32'h22);
    trg(10, 32'h3);
    rd(`CIL_A_STAT, 32'h132);
    wr(`CIL_A_CTRL, 32'h0);
    wr(`CIL_A_DEB1, 32'h2);
    lvl <= 4'h2;
    trg(8, 32'h0);
    lvl <= 4'h0;
    trg(40, 32'h0);
    lvl <= 4'h2;
    trg(10, 32'h0);
    trg(30, 32'h3);
    tally_and_finish();
  end
endmodule // cil_top_tb
`default_nettype wire
